// ===== rtl/pd_strap_pkg.sv
package pd_strap_pkg;

  // register offsets of the plain register port
  localparam logic [3:0] OFS_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h1;
  localparam logic [3:0] OFS_CONFIG   = 4'h2;
  localparam logic [3:0] OFS_ADDRESS  = 4'h3;
  localparam logic [3:0] OFS_MODE     = 4'h4;

  // control register bit positions
  localparam int CTL_EDPD_BIT   = 0;
  localparam int CTL_IRQEN_BIT  = 1;
  localparam int CTL_PDOWN_BIT  = 2;
  localparam int CTL_SRST_BIT   = 3;

  // status register bit positions
  localparam int ST_ENERGY_BIT  = 0;
  localparam int ST_EVENT_BIT   = 1;
  localparam int ST_HPD_BIT     = 2;
  localparam int ST_EDPD_BIT    = 3;

  // configuration and mode register field positions
  localparam int CFG_PAUSE_BIT  = 0;
  localparam int CFG_PLL_BIT    = 1;
  localparam int MODE_LSB       = 11;

  // level codes of a four-level configuration pin
  localparam logic [1:0] LVL_GND  = 2'h0;
  localparam logic [1:0] LVL_L100 = 2'h1;
  localparam logic [1:0] LVL_L1000 = 2'h2;
  localparam logic [1:0] LVL_VDD  = 2'h3;

  // operating-mode encodings for the auto-negotiating pin3 row
  localparam logic [4:0] MODE_ALL_AUTO = 5'h07;
  localparam logic [4:0] MODE_10_100   = 5'h04;
  localparam logic [4:0] MODE_ALL_SLV  = 5'h09;
  localparam logic [4:0] MODE_ALL_MST  = 5'h0A;
  localparam logic [4:0] MODE_RESET    = 5'h07;

  // reset values
  localparam logic       ENERGY_RESET  = 1'b1;

  // timing: energy flag hold after loss
  localparam int  ENERGY_HOLD_MS = 256;
  localparam int  CLK_MHZ        = 200;
  localparam longint ENERGY_HOLD_CYC = longint'(ENERGY_HOLD_MS) * 1000 * CLK_MHZ;

  // power state of the analog and PLL sections
  typedef struct packed {
    logic core_on;
    logic pll_on;
    logic tx_enable;
    logic squelch_on;
  } power_t;

  // captured hardware configuration
  typedef struct packed {
    logic [4:0] mode;
    logic       pause;
    logic       pll_keep;
    logic [2:0] address;
  } hwcfg_t;

  typedef enum logic [2:0] {
    PS_ACTIVE  = 3'b001,
    PS_EDPD    = 3'b010,
    PS_HPD     = 3'b100
  } pstate_t;

endpackage

// ===== rtl/phy_powerdown_strap_config.sv
// How it works
// R1 - detect on, no energy: no transmit; only mgmt, squelch, detector powered
// R2 - line energy sets flag, powers up, restores prior state, stays active
// R3 - with energy mask enabled, the line-energy event raises the interrupt
// R4 - hardware power-down pin asserted: everything off except management
// R5 - latched pll strap: low shuts pll in hardware power-down, high keeps it
// R6 - controller exits by releasing the pin, then clearing power-down bit
// R7 - with pll shut, controller also issues a software reset to finish exit
// R8 - pin held during reset: device comes out already in hardware power-down; code resets to active and enters it at the first clock after release
// R9 - strap pins tri-state in reset, drive after; level sampled at release
// R10 - outside logic never drives strap pins; only resistors set their level
// R11 - four configuration pins sampled at reset release give address and mode
// R12 - each pin resolves to level code 0 to 3 by its connection
// R13 - address bits 1:0 from pin 0 code, bit 2 from pin 1 code bit 0
// R14 - pause bit equals bit 1 of pin 1 level code
// R15 - software may set any five-bit address once communication works
// R16 - pins 3 and 2 set the five-bit mode field when reset completes
// R17 - after software reset pins have no effect; register values rule
// R18 - mode decode: pin3 code 2 gives 000xx, code 3 gives 7,4,9,10
// R19 - software reset never resamples straps or configuration pins
// R20 - flag clears a fixed 256 ms after line energy is lost, whether or not the interrupt is enabled
// R21 - all straps and pins captured together in one cycle after release
`timescale 1ns/100ps
`default_nettype none

module phy_powerdown_strap_config
  import pd_strap_pkg::*;
#(
  parameter longint HOLD_CYCLES = ENERGY_HOLD_CYC
) (
  // clock and reset
  input  wire  logic        SYS_CLK,
  input  wire  logic        RESET,
  // hardware pins
  input  wire  logic        HW_POWERDOWN_PIN,
  input  wire  logic        LINE_ENERGY_SENSE,
  input  wire  logic [7:0]  CONFIG_LEVEL,
  input  wire  logic        PLL_STRAP_IN,
  input  wire  logic        STRAP_DRIVE,
  output logic              PLL_STRAP_OUT,
  output logic              PLL_STRAP_OE,
  // register port
  input  wire  logic [3:0]  REG_ADDR,
  input  wire  logic [15:0] REG_WDATA,
  input  wire  logic        REG_WR,
  input  wire  logic        REG_RD,
  output logic [15:0]       REG_RDATA,
  // power and interrupt
  output logic              IRQ,
  output logic              CORE_ON,
  output logic              PLL_ON,
  output logic              TX_ENABLE,
  output logic              SQUELCH_ON
);

  localparam logic [31:0] HOLD_MAX = 32'(HOLD_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state

  pstate_t     state;
  pstate_t     next_state;
  hwcfg_t      hwcfg;
  logic        captured;
  logic        energy_pd_enable;
  logic        energy_irq_mask;
  logic        powerdown_bit;
  logic        line_energy_present;
  logic        energy_event;
  logic        hold_run;
  logic [31:0] hold_count;
  logic [4:0]  phy_bus_address;
  logic [4:0]  op_mode_field;
  logic        sense_q;
  power_t      power;

  ////////////////////////////////////////////////////////////////////////////
  // configuration pin decode

  logic [1:0] pin_level_code [4];

  // R12 - two bits per pin
  genvar g;
  for (g = 0; g < 4; g++) begin : g_pin
    assign pin_level_code[g] = CONFIG_LEVEL[2*g +: 2];
  end

  // R13 - address from pins
  wire [2:0] dec_address = {pin_level_code[1][0], pin_level_code[0]};
  // R14 - pause from pin 1
  wire       dec_pause   = pin_level_code[1][1];

  // R18 - mode table; pin3 at codes 0/1 falls back to the all-capable mode
  wire [4:0] mode_auto_row =
    (pin_level_code[2] == LVL_GND)  ? MODE_ALL_AUTO :
    (pin_level_code[2] == LVL_L100) ? MODE_10_100   :
    (pin_level_code[2] == LVL_L1000) ? MODE_ALL_SLV  : MODE_ALL_MST;
  wire [4:0] dec_mode =
    (pin_level_code[3] == LVL_L1000) ? {3'h0, pin_level_code[2]} :
    (pin_level_code[3] == LVL_VDD)   ? mode_auto_row : MODE_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_control = REG_WR && (REG_ADDR == OFS_CONTROL);
  wire wr_address = REG_WR && (REG_ADDR == OFS_ADDRESS);
  wire wr_mode    = REG_WR && (REG_ADDR == OFS_MODE);
  wire rd_status  = REG_RD && (REG_ADDR == OFS_STATUS);
  wire soft_reset = wr_control && REG_WDATA[CTL_SRST_BIT];

  wire energy_rise = LINE_ENERGY_SENSE && !sense_q;
  wire energy_fall = !LINE_ENERGY_SENSE && sense_q;
  wire hold_done   = hold_run && (hold_count == HOLD_MAX);

  // R5 - the capture edge itself already uses the strap, not the stale latch
  wire pll_keep_now = captured ? hwcfg.pll_keep : PLL_STRAP_IN;

  wire [15:0] ctl_view = {12'h000, 1'b0, powerdown_bit,
                          energy_irq_mask, energy_pd_enable};
  wire [15:0] st_view  = {12'h000, energy_pd_enable, state == PS_HPD,
                          energy_event, line_energy_present};
  wire [15:0] cfg_view = {14'h0000, hwcfg.pll_keep, hwcfg.pause};
  wire [15:0] rd_mux =
    (REG_ADDR == OFS_CONTROL) ? ctl_view :
    (REG_ADDR == OFS_STATUS)  ? st_view  :
    (REG_ADDR == OFS_CONFIG)  ? cfg_view :
    (REG_ADDR == OFS_ADDRESS) ? {11'h000, phy_bus_address} :
    (REG_ADDR == OFS_MODE)    ? {op_mode_field, 11'h000} : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // power state machine

  always_comb begin
    next_state = state;
    unique case (state)
      PS_ACTIVE: begin
        if (HW_POWERDOWN_PIN)
          next_state = PS_HPD;
        // R1 - sleep without energy
        else if (energy_pd_enable && !line_energy_present)
          next_state = PS_EDPD;
      end
      PS_EDPD: begin
        if (HW_POWERDOWN_PIN)
          next_state = PS_HPD;
        // R2 - wake on energy
        else if (LINE_ENERGY_SENSE || !energy_pd_enable)
          next_state = PS_ACTIVE;
      end
      PS_HPD: begin
        // R6 - pin low and power-down bit cleared; R7 - pll-off needs reset
        if (!HW_POWERDOWN_PIN && !powerdown_bit &&
            (hwcfg.pll_keep || soft_reset))
          next_state = PS_ACTIVE;
      end
      default: next_state = PS_ACTIVE;
    endcase
  end

  // power rails per state
  always_comb begin
    power = '{core_on: 1'b1, pll_on: 1'b1, tx_enable: 1'b1,
              squelch_on: 1'b1};
    if (next_state == PS_EDPD) begin
      // R1 - only detector alive
      power = '{core_on: 1'b0, pll_on: 1'b0, tx_enable: 1'b0,
                squelch_on: 1'b1};
    end else if (next_state == PS_HPD) begin
      // R4 R5 - all off, pll per strap
      power = '{core_on: 1'b0, pll_on: pll_keep_now, tx_enable: 1'b0,
                squelch_on: 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset capture; the pin is sampled by a clocked process after release

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      captured <= 1'b0;
      hwcfg    <= '0;
    end else if (!captured) begin
      // R21 - one-cycle capture; R11 R9 - pins and strap at release
      captured <= 1'b1;
      hwcfg    <= '{mode: dec_mode, pause: dec_pause,
                    pll_keep: PLL_STRAP_IN, address: dec_address};
    end
  end

  // R8 - pin held in reset enters hpd at first clock after release
  always_ff @(posedge SYS_CLK) begin
    if (RESET)
      state <= PS_ACTIVE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers; R17 R19 - soft reset keeps address and mode

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      energy_pd_enable <= 1'b0;
      energy_irq_mask  <= 1'b0;
      powerdown_bit    <= 1'b0;
      phy_bus_address  <= 5'h00;
      op_mode_field    <= MODE_RESET;
    end else begin
      if (!captured) begin
        // R13 - hardware address; R16 - mode field loaded once
        phy_bus_address <= {2'h0, dec_address};
        op_mode_field   <= dec_mode;
      end else begin
        // R15 - any five-bit address
        if (wr_address)
          phy_bus_address <= REG_WDATA[4:0];
        if (wr_mode)
          op_mode_field <= REG_WDATA[MODE_LSB +: 5];
      end
      if (wr_control) begin
        energy_pd_enable <= REG_WDATA[CTL_EDPD_BIT];
        energy_irq_mask  <= REG_WDATA[CTL_IRQEN_BIT];
        // a pin still held wins over a software clear
        powerdown_bit    <= REG_WDATA[CTL_PDOWN_BIT] || HW_POWERDOWN_PIN;
      end else if (HW_POWERDOWN_PIN) begin
        powerdown_bit    <= 1'b1;   // pin sets the bit software must clear
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line energy flag, event and hold timer

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sense_q             <= 1'b0;
      line_energy_present <= ENERGY_RESET;
      energy_event        <= 1'b0;
      hold_run            <= 1'b1;
      hold_count          <= 32'h0000_0000;
    end else begin
      sense_q <= LINE_ENERGY_SENSE;
      // R2 - flag set on energy
      if (energy_rise) begin
        line_energy_present <= 1'b1;
        hold_run            <= 1'b0;
      end else if (energy_fall) begin
        hold_run   <= 1'b1;
        hold_count <= 32'h0000_0000;
      // R20 - clear after hold
      end else if (hold_done) begin
        line_energy_present <= 1'b0;
        hold_run            <= 1'b0;
      end else if (hold_run) begin
        hold_count <= hold_count + 32'h0000_0001;
      end
      // event sticky; set beats the read clear
      if (energy_rise || energy_fall)
        energy_event <= 1'b1;
      else if (rd_status)
        energy_event <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RDATA     <= 16'h0000;
      IRQ           <= 1'b0;
      CORE_ON       <= 1'b1;
      PLL_ON        <= 1'b1;
      TX_ENABLE     <= 1'b0;
      SQUELCH_ON    <= 1'b1;
      PLL_STRAP_OUT <= 1'b0;
      PLL_STRAP_OE  <= 1'b0;   // R9 - tri-state in reset
    end else begin
      REG_RDATA     <= REG_RD ? rd_mux : 16'h0000;
      // R3 - masked interrupt
      IRQ           <= energy_irq_mask &&
                       (energy_event || energy_rise || energy_fall) &&
                       !rd_status;
      CORE_ON       <= power.core_on;
      PLL_ON        <= power.pll_on;
      TX_ENABLE     <= power.tx_enable;
      SQUELCH_ON    <= power.squelch_on;
      // R9 - drive function output once captured
      PLL_STRAP_OUT <= STRAP_DRIVE;
      PLL_STRAP_OE  <= captured;
    end
  end

endmodule

`default_nettype wire

// ===== tb/pd_strap_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pd_strap_checker
  import pd_strap_pkg::*;
#(
  parameter longint HOLD_CYCLES = ENERGY_HOLD_CYC
) (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  // pins
  input wire logic        HW_POWERDOWN_PIN,
  input wire logic        LINE_ENERGY_SENSE,
  input wire logic [7:0]  CONFIG_LEVEL,
  input wire logic        PLL_STRAP_IN,
  input wire logic        PLL_STRAP_OE,
  // register port
  input wire logic [3:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  // power and interrupt
  input wire logic        IRQ,
  input wire logic        CORE_ON,
  input wire logic        PLL_ON,
  input wire logic        TX_ENABLE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic       rst_d;
  logic       pll_q;
  logic [7:0] lvl_q;
  logic       addr_ok;
  logic [4:0] addr_q;
////////////////////////////////////////
  // own copy of the capture edge, so checks never trust the design's latch
  always_ff @(posedge SYS_CLK) begin
    rst_d <= RESET;
    if (rst_d && !RESET) begin
      pll_q <= PLL_STRAP_IN;
      lvl_q <= CONFIG_LEVEL;
    end
    // last address written outside the capture cycle
    if (RESET)
      addr_ok <= 1'b0;
    else if (!rst_d && REG_WR && REG_ADDR == OFS_ADDRESS) begin
      addr_ok <= 1'b1;
      addr_q  <= REG_WDATA[4:0];
    end
  end
////////////////////////////////////////
  strap_hiz_a: assert property ($past(RESET) |-> !PLL_STRAP_OE)
    else $error("strap driven in capture cycle");
  strap_drive_a: assert property (
    $past(RESET, 2) && !$past(RESET) |=> PLL_STRAP_OE)
    else $error("strap not driven after capture");
  tx_gate_a: assert property (!CORE_ON |-> !TX_ENABLE)
    else $error("transmit while core is down");
  hpd_core_a: assert property (
    HW_POWERDOWN_PIN [*3] |-> !CORE_ON && !TX_ENABLE)
    else $error("core up under power-down pin");
  hpd_pll_a: assert property (HW_POWERDOWN_PIN [*3] |-> PLL_ON == pll_q)
    else $error("pll state ignores strap");
  addr_store_a: assert property (
    REG_RD && REG_ADDR == OFS_ADDRESS && addr_ok |=> REG_RDATA[4:0] == addr_q)
    else $error("address write lost");
  cfg_read_a: assert property (
    REG_RD && REG_ADDR == OFS_CONFIG |=> REG_RDATA[1:0] == {pll_q, lvl_q[3]})
    else $error("captured config read wrong");
  irq_clear_a: assert property (
    $stable(LINE_ENERGY_SENSE) [*6] ##0 (REG_RD && REG_ADDR == OFS_STATUS)
    ##1 $stable(LINE_ENERGY_SENSE) [*2] |-> !IRQ)
    else $error("request stayed up after status read");
  // main scenarios reached
  cover property (HW_POWERDOWN_PIN [*3]);
  cover property ($rose(IRQ));
  cover property (REG_RD && REG_ADDR == OFS_CONFIG);
endmodule
bind phy_powerdown_strap_config pd_strap_checker #(.HOLD_CYCLES(HOLD_CYCLES))
  u_chk (.SYS_CLK, .RESET, .HW_POWERDOWN_PIN, .LINE_ENERGY_SENSE,
  .CONFIG_LEVEL, .PLL_STRAP_IN, .PLL_STRAP_OE, .REG_ADDR, .REG_WDATA,
  .REG_WR, .REG_RD, .REG_RDATA, .IRQ, .CORE_ON, .PLL_ON, .TX_ENABLE);
`default_nettype wire

// ===== tb/strap_resistor_model.sv
`timescale 1ns/100ps
`default_nettype none
module strap_resistor_model (
  // device side
  input  wire logic strap_oe,
  input  wire logic strap_out,
  // board side
  input  wire logic pull_up,
  output logic      pin_level
);
  // resistor only
  // the board never fights the device; a floating pin reads the resistor
  assign pin_level = strap_oe ? strap_out : pull_up;
endmodule
`default_nettype wire

// ===== tb/test_phy_powerdown_strap_config.sv
`timescale 1ns/100ps
`default_nettype none
module test_phy_powerdown_strap_config
  import pd_strap_pkg::*;
;
  logic        sys_clk, reset, hpd_pin, sense, pull_up, drive;
  logic        strap_pin, strap_out, strap_oe, reg_wr, reg_rd;
  logic        irq, core_on, pll_on, tx_enable, squelch_on;
  logic [7:0]  level;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
////////////////////////////////////////
  // short hold keeps the energy timer inside the run
  phy_powerdown_strap_config #(.HOLD_CYCLES(20)) u_dut (
    .SYS_CLK(sys_clk), .RESET(reset), .HW_POWERDOWN_PIN(hpd_pin),
    .LINE_ENERGY_SENSE(sense), .CONFIG_LEVEL(level),
    .PLL_STRAP_IN(strap_pin), .STRAP_DRIVE(drive),
    .PLL_STRAP_OUT(strap_out), .PLL_STRAP_OE(strap_oe),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq), .CORE_ON(core_on),
    .PLL_ON(pll_on), .TX_ENABLE(tx_enable), .SQUELCH_ON(squelch_on));
  strap_resistor_model u_strap (.strap_oe(strap_oe), .strap_out(strap_out),
    .pull_up(pull_up), .pin_level(strap_pin));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // a hang ends the run as a failure
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end
////////////////////////////////////////
  task automatic stop_test();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic hw_reset(input logic [7:0] lv, input logic pu,
                          input logic pd);
    @(posedge sys_clk);
    reset <= 1'b1;
    level <= lv;
    pull_up <= pu;
    hpd_pin <= pd;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
////////////////////////////////////////
  // every pin code pair, mode rows of pin3 codes 2 and 3
  task automatic t_config();
    logic [1:0] p1, p2;
    logic [4:0] m;
    for (int i = 0; i < 16; i++) begin
      p1 = i[3:2];
      p2 = i[1:0];
      m = p2[1] ? (p2[0] ? 5'h0A : 5'h09) : (p2[0] ? 5'h04 : 5'h07);
      if (!i[3])
        m = {3'h0, p2};
      hw_reset({1'b1, i[3], p2, p1, ~p2}, i[0], 1'b0);
      rd(OFS_ADDRESS);
      chk(rv, {13'h0000, p1[0], ~p2});
      rd(OFS_CONFIG);
      chk(rv, {14'h0000, i[0], p1[1]});
      rd(OFS_MODE);
      chk(rv, {m, 11'h000});
      chk({15'h0000, strap_pin}, 16'h0001);
    end
  endtask
  // software reset keeps register values, pins changed meanwhile
  task automatic t_soft();
    hw_reset(8'hE4, 1'b0, 1'b0);
    wr(OFS_ADDRESS, 16'h001B);
    rd(OFS_ADDRESS);
    chk(rv, 16'h001B);
    wr(OFS_MODE, 16'h1800);
    level <= 8'h1B;
    pull_up <= 1'b1;
    wr(OFS_CONTROL, 16'h0008);
    wait_cyc(4);
    rd(OFS_ADDRESS);
    chk(rv, 16'h001B);
    rd(OFS_MODE);
    chk(rv, 16'h1800);
    rd(OFS_CONFIG);
    chk(rv, 16'h0000);
  endtask
  // pin held in reset, then exit by pin and bit, plus software reset for the pll-off strap
  task automatic t_hpd();
    for (int k = 0; k < 2; k++) begin
      hw_reset(8'h00, k[0], 1'b1);
      rd(OFS_STATUS);
      chk({15'h0000, rv[ST_HPD_BIT]}, 16'h0001);
      chk({12'h000, core_on, pll_on, tx_enable, squelch_on},
          {12'h000, 1'b0, k[0], 2'b00});
      hpd_pin <= 1'b0;
      wait_cyc(4);
      chk({15'h0000, core_on}, 16'h0000);
      // clear the bit first; a pll-off exit waits for the soft reset
      wr(OFS_CONTROL, 16'h0000);
      wait_cyc(4);
      chk({15'h0000, core_on}, {15'h0000, k[0]});
      if (!k[0])
        wr(OFS_CONTROL, 16'h0008);
      wait_cyc(4);
      chk({14'h0000, core_on, pll_on}, 16'h0003);
    end
  endtask
  // loss and return of line energy, masked and unmasked
  task automatic t_edpd();
    hw_reset(8'h00, 1'b0, 1'b0);
    sense <= 1'b1;
    wr(OFS_CONTROL, 16'h0003);
    rd(OFS_STATUS);
    // status read drops the request while the line is quiet
    wait_cyc(2);
    chk({15'h0000, irq}, 16'h0000);
    sense <= 1'b0;
    wait_cyc(4);
    chk({15'h0000, irq}, 16'h0001);
    rd(OFS_STATUS);
    chk(rv, 16'h000B);
    wait_cyc(30);
    chk({15'h0000, irq}, 16'h0000);
    rd(OFS_STATUS);
    chk(rv, 16'h0008);
    chk({13'h0000, core_on, tx_enable, squelch_on}, 16'h0001);
    sense <= 1'b1;
    wait_cyc(4);
    chk({13'h0000, core_on, tx_enable, squelch_on}, 16'h0007);
    rd(OFS_STATUS);
    chk(rv, 16'h000B);
    wr(OFS_CONTROL, 16'h0001);
    sense <= 1'b0;
    wait_cyc(4);
    chk({15'h0000, irq}, 16'h0000);
  endtask
////////////////////////////////////////
  // inputs known from time zero, reset for 16 cycles
  initial begin
    {reset, hpd_pin, sense, pull_up, drive} <= 5'b10101;
    {reg_wr, reg_rd, level, reg_addr, reg_wdata} <= '0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_config();
    t_soft();
    t_hpd();
    t_edpd();
    stop_test();
  end
endmodule
`default_nettype wire
